// ### dv/adc_range_alarm_registers_tb.sv
// self-checking bench with a behavioural model of the range and alarm bank
`timescale 1ns/1ns
module adc_range_alarm_registers_tb;
   logic        mclk;                    // 20 mhz clock
   logic        rst;                     // async reset
   logic [7:0]  addr;                    // from host model
   logic [31:0] wdata;                   // from host model
   logic        wr;                      // from host model
   logic        rd;                      // from host model
   logic [31:0] rdata;                   // read data
   logic [15:0] result;                  // conversion result
   logic        result_valid;            // result strobe
   logic        sup_lo;                  // supply low detector
   logic        sup_hi;                  // supply high detector
   logic        onchip_ref_off;          // reference disable
   logic [3:0]  span_code;               // span to analog
   logic [7:0]  supply_high_limit;       // supply limit select
   logic        frame_valid;             // frame strobe
   logic [19:0] frame_data;             // frame word
   logic        span_in_output_frame;    // include bit
   logic        irq;                     // interrupt level
   int          err_total;               // mismatches
   int          comparisons;             // compares made
   int          cycles;                  // timeout counter
   int          hi_m, lo_m, hyst_m;      // model thresholds
   logic [31:0] span_m, incl_m;          // model span and include bit
   logic [3:0]  live_m, trip_m, stat_m;  // order: in_hi, in_lo, sup_hi, sup_lo
   logic [31:0] rv, d;                   // scratch
   int          seq[$] = '{1001, 995, 990, 50, 105, 109, 500};

   ara_host i_ara_host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   adc_range_alarm_registers i_adc_range_alarm_registers (.mclk(mclk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .result(result),
      .result_valid(result_valid), .supply_low_det(sup_lo), .supply_high_det(sup_hi),
      .onchip_ref_off(onchip_ref_off), .span_code(span_code),
      .supply_high_limit(supply_high_limit), .frame_valid(frame_valid),
      .frame_data(frame_data), .span_in_output_frame(span_in_output_frame), .irq(irq));

   // free-running clock, 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // a hang is cut short well beyond the few hundred cycles the tests need
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         finish_test();
      end
   end

   // compare one value and count it
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // model of the alarm word built from live and tripped flags
   function automatic logic [31:0] alarm_word();
      return {16'h0, live_m[3], live_m[2], 2'b0, live_m[1], live_m[0], 2'b0,
              trip_m[3], trip_m[2], trip_m[1], trip_m[0], 3'b0, |trip_m};
   endfunction

   // live flag update; rising edge is an interrupt event, live sets the trip flag
   task automatic set_live(input int i, input logic v);
      if (v && !live_m[i]) stat_m[i] = 1'b1;
      if (v) trip_m[i] = 1'b1;
      live_m[i] = v;
   endtask

   // read and compare; an alarm read clears tripped flags whose condition is gone
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      i_ara_host.read_reg(a, rv);
      chk($sformatf("reg %h", a), rv, exp);
      if (a == 8'h20) trip_m = trip_m & live_m;
   endtask

   // one conversion result, checked on the frame in the cycle after it is taken
   task automatic send(input int r);
      @(posedge mclk);
      result       <= r[15:0];
      result_valid <= 1'b1;
      @(posedge mclk);
      result_valid <= 1'b0;
      result       <= ~r[15:0];
      @(posedge mclk);
      chk("frame_valid", frame_valid, 1'b1);
      chk("frame_data", frame_data, {r[15:0], incl_m[8] ? span_m[3:0] : 4'h0});
      if (r > hi_m) set_live(0, 1'b1);
      else if (r + hyst_m < hi_m) set_live(0, 1'b0);
      if (r < lo_m) set_live(1, 1'b1);
      else if (r > lo_m + hyst_m) set_live(1, 1'b0);
      repeat (3) @(posedge mclk);
   endtask

   // run the tests in order, then the verdict
   initial begin
      rst = 1'b1; result = 16'h0; result_valid = 1'b0; sup_lo = 1'b0; sup_hi = 1'b0;
      err_total = 0; comparisons = 0; cycles = 0;
      hi_m = 16'hffff; lo_m = 0; hyst_m = 0; span_m = 0; incl_m = 0;
      live_m = 4'h0; trip_m = 4'h0; stat_m = 4'h0;
      void'($urandom(88724));
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      // reset values
      rd_chk(8'h14, 32'h0);
      rd_chk(8'h20, 32'h0);
      rd_chk(8'h24, 32'h0000ffff);
      rd_chk(8'h28, 32'h0);
      rd_chk(8'h10, 32'h0);
      rd_chk(8'h40, 32'h0);
      rd_chk(8'h44, 32'h0);
      chk("irq", irq, 1'b0);
      $display("test reset done");
      // every span code with random reference and reserved bits; code 9 is skipped
      for (int c = 0; c < 16; c++) begin
         if (c == 9) continue;
         d = $urandom;
         d[3:0] = c[3:0];
         span_m = d & 32'h4f;
         i_ara_host.write_reg(8'h14, d);
         rd_chk(8'h14, span_m);
         chk("span_code", span_code, c[3:0]);
         chk("onchip_ref_off", onchip_ref_off, d[6]);
      end
      $display("test span done");
      // read-only alarm word, unmapped and misaligned places
      i_ara_host.write_reg(8'h20, 32'hffffffff);
      rd_chk(8'h20, alarm_word());
      rd_chk(8'h18, 32'h0);
      rd_chk(8'h15, 32'h0);
      // threshold words; the hysteresis low bits are written as zero
      d = $urandom;
      d[25:24] = 2'b00;
      i_ara_host.write_reg(8'h24, d);
      rd_chk(8'h24, d & 32'hfcffffff);
      chk("supply_high_limit", supply_high_limit, d[23:16]);
      d = $urandom;
      i_ara_host.write_reg(8'h28, d);
      rd_chk(8'h28, d & 32'hffff);
      $display("test limits done");
      // input alarm set, held inside hysteresis, released, tripped cleared on read
      incl_m = 32'h100;
      i_ara_host.write_reg(8'h10, 32'hffffffff);
      @(posedge mclk);
      chk("span_in_output_frame", span_in_output_frame, 1'b1);
      hi_m = 1000; lo_m = 100; hyst_m = 8;
      i_ara_host.write_reg(8'h24, {8'h08, 8'h01, 16'd1000});
      i_ara_host.write_reg(8'h28, 32'd100);
      foreach (seq[k]) begin
         send(seq[k]);
         rd_chk(8'h20, alarm_word());
      end
      rd_chk(8'h20, alarm_word());
      $display("test input alarm done");
      // supply detectors, live then tripped, cleared by the first read after release, checked by a second
      for (int i = 2; i < 4; i++) begin
         if (i == 2) sup_hi <= 1'b1;
         else sup_lo <= 1'b1;
         set_live(i, 1'b1);
         repeat (4) @(posedge mclk);
         rd_chk(8'h20, alarm_word());
         sup_hi <= 1'b0;
         sup_lo <= 1'b0;
         set_live(i, 1'b0);
         repeat (4) @(posedge mclk);
         rd_chk(8'h20, alarm_word());
         rd_chk(8'h20, alarm_word());
      end
      $display("test supply done");
      // interrupt: status sticky, mask gating, write-one clear
      rd_chk(8'h40, {28'h0, stat_m});
      i_ara_host.write_reg(8'h40, 32'hf);
      stat_m = 4'h0;
      i_ara_host.write_reg(8'h44, 32'h1);
      send(2000);
      chk("irq set", irq, 1'b1);
      i_ara_host.write_reg(8'h44, 32'h0);
      repeat (2) @(posedge mclk);
      chk("irq masked", irq, 1'b0);
      i_ara_host.write_reg(8'h44, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq unmasked", irq, 1'b1);
      rd_chk(8'h40, {28'h0, stat_m});
      i_ara_host.write_reg(8'h40, 32'h1);
      stat_m = 4'h0;
      repeat (2) @(posedge mclk);
      chk("irq cleared", irq, 1'b0);
      rd_chk(8'h40, 32'h0);
      $display("test interrupt done");
      finish_test();
   end

   // counts, verdict and end of run
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
endmodule // adc_range_alarm_registers_tb

// ### dv/ara_host.sv
// host controller model driving the register port of the range and alarm bank
`timescale 1ns/1ns
module ara_host (
   input  wire logic        mclk,
   output logic [7:0]       addr,
   output logic [31:0]      wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata
);
   // idle bus at time zero; strobes low
   initial begin
      addr  = 8'h00;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   // one-cycle write; address and data inverted afterwards so stale values never match
   task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
   endtask

   // one-cycle read; data stands only in the cycle after the strobe
   task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      addr <= ~a;
      @(posedge mclk);
      d = rdata;
   endtask
endmodule // ara_host

// ### src/adc_range_alarm_registers.sv
// range select, alarm flag and alarm threshold register bank
`timescale 1ns/1ns
`include "ara_map.svh"
module adc_range_alarm_registers #(
   parameter int ADDR_W = 8           // byte address width
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [31:0]            rdata,
   input  wire logic [15:0]       result,
   input  wire logic              result_valid,
   input  wire logic              supply_low_det,
   input  wire logic              supply_high_det,
   output logic                   onchip_ref_off,
   output logic [3:0]             span_code,
   output logic [7:0]             supply_high_limit,
   output logic                   frame_valid,
   output logic [19:0]            frame_data,
   output logic                   span_in_output_frame,
   output logic                   irq
);
   // refuse an address bus too narrow to reach the interrupt registers
   if (ADDR_W < 7) begin : g_chk
      $error("ADDR_W must be at least 7");
   end

   ara_cmp_if cif ();                      // to the comparator

   // software-visible state and the live-flag history
   ara_pkg::ara_span_t span_q;             // input span code
   logic               ref_off_q;          // reference disable
   logic               span_incl_q;        // append span to frames
   logic [5:0]         hyst_q;             // significant hysteresis bits
   logic [7:0]         sup_limit_q;        // supply high limit select
   logic [15:0]        upper_q;            // high input threshold
   logic [15:0]        lower_q;            // low input threshold
   logic [3:0]         trip_q;             // tripped flags, event order
   logic [3:0]         live_prev_q;        // live flags one cycle ago
   logic [3:0]         stat_q;             // interrupt status
   logic [3:0]         mask_q;             // interrupt mask
   logic               sup_lo_q;           // registered supply low
   logic               sup_hi_q;           // registered supply high
   // output flops
   logic [31:0]        rdata_q;
   logic               frame_valid_q;
   logic [19:0]        frame_data_q;
   logic               irq_q;

   // decode
   logic [3:0]         live;               // live flags, event order
   logic               wr_span;
   logic               wr_ctl;
   logic               wr_hi;
   logic               wr_lo;
   logic               wr_stat;
   logic               wr_mask;
   logic               rd_alarm;
   logic [31:0]        alarm_word;         // assembled alarm register
   logic [31:0]        rd_word;            // mux output

   // full byte address must match, so a stray low address bit is unmapped
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   assign wr_span  = wr && hit(addr, `ARA_OFS_SPAN);
   assign wr_ctl   = wr && hit(addr, `ARA_OFS_OUT_CTL);
   assign wr_hi    = wr && hit(addr, `ARA_OFS_HI_LIMIT);
   assign wr_lo    = wr && hit(addr, `ARA_OFS_LO_LIMIT);
   assign wr_stat  = wr && hit(addr, `ARA_OFS_IRQ_STAT);
   assign wr_mask  = wr && hit(addr, `ARA_OFS_IRQ_MASK);
   // a write to the alarm offset decodes to nothing at all
   assign rd_alarm = rd && hit(addr, `ARA_OFS_ALARM);

   assign live = {sup_lo_q, sup_hi_q, cif.in_lo, cif.in_hi};

   // comparator feed; hysteresis carries two forced zero lsbs
   assign cif.result    = result;
   assign cif.res_valid = result_valid;
   assign cif.upper     = upper_q;
   assign cif.lower     = lower_q;
   assign cif.hyst      = {hyst_q, 2'b00};

   ara_alarm_cmp u_cmp (
      .mclk (mclk),
      .rst  (rst),
      .cif  (cif)
   );

   // span register: reference disable and span code
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ref_off_q <= 1'b0;
         span_q    <= ara_pkg::ara_span_t'(`ARA_RST_SPAN);
      end else if (wr_span) begin
         ref_off_q <= wdata[`ARA_BIT_REF_OFF];
         // all sixteen codes are stored; the analog side decodes them
         span_q    <= ara_pkg::ara_span_t'(wdata[3:0]);
      end
   end

   // output control: only the span-include bit lives here
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         span_incl_q <= 1'b0;
      end else if (wr_ctl) begin
         span_incl_q <= wdata[`ARA_BIT_SPAN_INCL];
      end
   end

   // high limit word; hysteresis lsbs are dropped, not stored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hyst_q      <= `ARA_RST_HYST;
         sup_limit_q <= `ARA_RST_SUP_LIMIT;
         upper_q     <= `ARA_RST_UPPER;
      end else if (wr_hi) begin
         hyst_q      <= wdata[31:26];
         sup_limit_q <= wdata[23:16];
         upper_q     <= wdata[15:0];
      end
   end

   // low input threshold
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lower_q <= `ARA_RST_LOWER;
      end else if (wr_lo) begin
         lower_q <= wdata[15:0];
      end
   end

   // supply detectors arrive synchronous; one flop aligns them with the read path
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sup_lo_q <= 1'b0;
         sup_hi_q <= 1'b0;
      end else begin
         sup_lo_q <= supply_low_det;
         sup_hi_q <= supply_high_det;
      end
   end

   // tripped flags: a live condition sets them, a read clears the ones now quiet;
   // set wins, so an alarm present during the read survives it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trip_q <= 4'h0;
      end else if (rd_alarm) begin
         trip_q <= live;
      end else begin
         trip_q <= trip_q | live;
      end
   end

   // interrupt events are fresh rising edges of the live flags
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         live_prev_q <= 4'h0;
      end else begin
         live_prev_q <= live;
      end
   end

   // interrupt status, write one to clear, new event beats the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~(wr_stat ? wdata[3:0] : 4'h0)) | (live & ~live_prev_q);
      end
   end

   // interrupt mask
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mask_q <= 4'h0;
      end else if (wr_mask) begin
         mask_q <= wdata[3:0];
      end
   end

   // level interrupt, one cycle behind the status it reflects
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   // alarm word: reserved bits tied low
   always_comb begin
      alarm_word = 32'h0000_0000;
      alarm_word[`ARA_BIT_SUP_LO_LIVE] = sup_lo_q;
      alarm_word[`ARA_BIT_SUP_HI_LIVE] = sup_hi_q;
      alarm_word[`ARA_BIT_IN_LO_LIVE]  = cif.in_lo;
      alarm_word[`ARA_BIT_IN_HI_LIVE]  = cif.in_hi;
      alarm_word[`ARA_BIT_SUP_LO_TRIP] = trip_q[ara_pkg::ARA_EV_SUP_LO];
      alarm_word[`ARA_BIT_SUP_HI_TRIP] = trip_q[ara_pkg::ARA_EV_SUP_HI];
      alarm_word[`ARA_BIT_IN_LO_TRIP]  = trip_q[ara_pkg::ARA_EV_IN_LO];
      alarm_word[`ARA_BIT_IN_HI_TRIP]  = trip_q[ara_pkg::ARA_EV_IN_HI];
      alarm_word[`ARA_BIT_ANY_TRIP]    = |trip_q;
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit(addr, `ARA_OFS_SPAN)) begin
         rd_word = {25'h0000000, ref_off_q, 2'b00, span_q};
      end else if (hit(addr, `ARA_OFS_OUT_CTL)) begin
         rd_word = {23'h000000, span_incl_q, 8'h00};
      end else if (hit(addr, `ARA_OFS_ALARM)) begin
         rd_word = alarm_word;
      end else if (hit(addr, `ARA_OFS_HI_LIMIT)) begin
         rd_word = {hyst_q, 2'b00, sup_limit_q, upper_q};
      end else if (hit(addr, `ARA_OFS_LO_LIMIT)) begin
         rd_word = {16'h0000, lower_q};
      end else if (hit(addr, `ARA_OFS_IRQ_STAT)) begin
         rd_word = {28'h0000000, stat_q};
      end else if (hit(addr, `ARA_OFS_IRQ_MASK)) begin
         rd_word = {28'h0000000, mask_q};
      end
   end

   // read data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd) begin
         rdata_q <= rd_word;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // output frame: result with span in the low nibble when enabled, flagged for every result
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         frame_valid_q <= 1'b0;
         frame_data_q  <= 20'h00000;
      end else begin
         frame_valid_q <= result_valid;
         if (result_valid) begin
            // span taken at conversion time, so a late write cannot tear the frame
            frame_data_q <= {result, span_incl_q ? span_q : 4'h0};
         end
      end
   end

   assign rdata                = rdata_q;
   assign onchip_ref_off       = ref_off_q;
   assign span_code            = span_q;
   assign supply_high_limit    = sup_limit_q;
   assign span_in_output_frame = span_incl_q;
   assign frame_valid          = frame_valid_q;
   assign frame_data           = frame_data_q;
   assign irq                  = irq_q;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // a write, one idle cycle, then a read-back of the span word
   a_ref_off_write: assert property (
      wr_span ##2 rd && hit(addr, `ARA_OFS_SPAN) |=> rdata_q[6] == $past(wdata[6], 3))
      else $error("reference disable bit did not store");
   a_span_rsvd_zero: assert property (
      rd && hit(addr, `ARA_OFS_SPAN) |=> rdata_q[31:7] == 25'h0 && rdata_q[5:4] == 2'b00)
      else $error("span reserved bits read nonzero");
   a_live_input_read: assert property (
      rd_alarm |=> rdata_q[11] == $past(cif.in_lo) && rdata_q[10] == $past(cif.in_hi))
      else $error("live input flags misreported");
   a_supply_live_flag: assert property (
      supply_low_det |=> sup_lo_q ##1 trip_q[ara_pkg::ARA_EV_SUP_LO])
      else $error("supply low did not show live and tripped");
   a_trip_stays_set: assert property (
      trip_q[ara_pkg::ARA_EV_IN_HI] && !rd_alarm |=> trip_q[ara_pkg::ARA_EV_IN_HI])
      else $error("tripped flag dropped without a read");
   a_summary_or: assert property (
      rd_alarm |=> rdata_q[0] == |rdata_q[7:4])
      else $error("summary bit is not the OR of tripped flags");
   a_hyst_lsb_zero: assert property (
      rd && hit(addr, `ARA_OFS_HI_LIMIT) |=> rdata_q[25:24] == 2'b00)
      else $error("hysteresis low bits read nonzero");
   a_frame_span: assert property (
      result_valid && span_incl_q |=> frame_valid_q && frame_data_q[3:0] == $past(span_q))
      else $error("frame lost its span nibble");
   a_irq_follows: assert property (
      (stat_q & mask_q) != 4'h0 |=> irq_q)
      else $error("interrupt not raised for unmasked status");

   // stores land one cycle after their strobe, straight from the write data
   a_ref_off_store: assert property (
      wr_span |=> ref_off_q == $past(wdata[`ARA_BIT_REF_OFF]))
      else $error("reference disable bit not taken from write");
   a_span_store: assert property (
      wr_span |=> span_q == $past(wdata[3:0]))
      else $error("span code not taken from write");
   a_hyst_store: assert property (
      wr_hi |=> hyst_q == $past(wdata[31:26]))
      else $error("hysteresis not taken from write");
   a_sup_limit_store: assert property (
      wr_hi |=> sup_limit_q == $past(wdata[23:16]))
      else $error("supply limit not taken from write");
   a_upper_store: assert property (
      wr_hi |=> upper_q == $past(wdata[15:0]))
      else $error("high input threshold not taken from write");
   a_lower_store: assert property (
      wr_lo |=> lower_q == $past(wdata[15:0]))
      else $error("low input threshold not taken from write");
   // a read while nothing is live must leave every tripped flag clear
   a_trip_read_clear: assert property (
      rd_alarm && live == 4'h0 |=> trip_q == 4'h0)
      else $error("tripped flags survived a read with no condition");
   a_trip_set_live: assert property (
      cif.in_hi |=> trip_q[ara_pkg::ARA_EV_IN_HI])
      else $error("input high trip flag missed a live alarm");
   a_rdata_idle: assert property (
      !rd |=> rdata_q == 32'h0000_0000)
      else $error("read data present without a read strobe");

   c_trip_cleared: cover property (trip_q != 4'h0 ##1 rd_alarm ##1 trip_q == 4'h0);
   c_irq_raised: cover property (!irq_q ##1 irq_q);
   c_frame_incl: cover property (result_valid && span_incl_q);
   c_low_held: cover property (cif.res_valid && cif.in_lo ##1 cif.in_lo);
   c_supply_trip: cover property (sup_lo_q ##1 trip_q[ara_pkg::ARA_EV_SUP_LO]);
endmodule // adc_range_alarm_registers

// ### src/ara_alarm_cmp.sv
// input alarm comparator with hysteresis on release
`timescale 1ns/1ns
module ara_alarm_cmp (
   input wire logic mclk,
   input wire logic rst,
   ara_cmp_if.cmp   cif
);
   // 17-bit sums so a threshold near full scale cannot wrap
   logic [16:0] res_plus;  // result plus hysteresis
   logic [16:0] low_plus;  // lower threshold plus hysteresis
   logic        in_hi_q;   // live high flag
   logic        in_lo_q;   // live low flag

   assign res_plus = {1'b0, cif.result} + {9'h000, cif.hyst};
   assign low_plus = {1'b0, cif.lower} + {9'h000, cif.hyst};

   // high alarm: set above threshold, release only below threshold minus hysteresis
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_hi_q <= 1'b0;
      end else if (cif.res_valid) begin
         if (in_hi_q) begin
            in_hi_q <= !(res_plus < {1'b0, cif.upper});
         end else begin
            in_hi_q <= cif.result > cif.upper;
         end
      end
   end

   // low alarm: set below threshold, release only above threshold plus hysteresis
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_lo_q <= 1'b0;
      end else if (cif.res_valid) begin
         if (in_lo_q) begin
            in_lo_q <= !({1'b0, cif.result} > low_plus);
         end else begin
            in_lo_q <= cif.result < cif.lower;
         end
      end
   end

   assign cif.in_hi = in_hi_q;
   assign cif.in_lo = in_lo_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_high_sets_above: assert property (
      cif.res_valid && !in_hi_q && (cif.result > cif.upper) |=> in_hi_q)
      else $error("high alarm missed a result above threshold");
   a_low_holds_band: assert property (
      cif.res_valid && in_lo_q && ({1'b0, cif.result} <= low_plus) |=> in_lo_q)
      else $error("low alarm released inside hysteresis band");
endmodule // ara_alarm_cmp

// ### src/ara_cmp_if.sv
// link between the register bank and the input alarm comparator
`timescale 1ns/1ns
interface ara_cmp_if;
   logic [15:0] result;     // conversion result
   logic        res_valid;  // one-cycle result strobe
   logic [15:0] upper;      // high input threshold
   logic [15:0] lower;      // low input threshold
   logic [7:0]  hyst;       // hysteresis amount
   logic        in_hi;      // live high input alarm
   logic        in_lo;      // live low input alarm
   modport regs (output result, res_valid, upper, lower, hyst, input in_hi, in_lo);
   modport cmp  (input result, res_valid, upper, lower, hyst, output in_hi, in_lo);
endinterface

// ### src/ara_map.svh
// register offsets, field positions and reset values of the range and alarm bank
`ifndef ARA_MAP_SVH
`define ARA_MAP_SVH
`define ARA_OFS_OUT_CTL      8'h10
`define ARA_OFS_SPAN         8'h14
`define ARA_OFS_ALARM        8'h20
`define ARA_OFS_HI_LIMIT     8'h24
`define ARA_OFS_LO_LIMIT     8'h28
`define ARA_OFS_IRQ_STAT     8'h40
`define ARA_OFS_IRQ_MASK     8'h44
`define ARA_BIT_SPAN_INCL    8
`define ARA_BIT_REF_OFF      6
`define ARA_BIT_SUP_LO_LIVE  15
`define ARA_BIT_SUP_HI_LIVE  14
`define ARA_BIT_IN_LO_LIVE   11
`define ARA_BIT_IN_HI_LIVE   10
`define ARA_BIT_SUP_LO_TRIP  7
`define ARA_BIT_SUP_HI_TRIP  6
`define ARA_BIT_IN_LO_TRIP   5
`define ARA_BIT_IN_HI_TRIP   4
`define ARA_BIT_ANY_TRIP     0
`define ARA_RST_SPAN         4'h0
`define ARA_RST_HYST         6'h00
`define ARA_RST_SUP_LIMIT    8'h00
`define ARA_RST_UPPER        16'hffff
`define ARA_RST_LOWER        16'h0000
`endif

// ### src/ara_pkg.sv
// types shared by the range and alarm bank
package ara_pkg;
   // input span codes; 4'h9 is undefined and must not be programmed
   typedef enum logic [3:0] {
      ARA_SE_3P0 = 4'h0, ARA_SE_2P5 = 4'h1, ARA_SE_1P5 = 4'h2, ARA_SE_1P25 = 4'h3,
      ARA_SE_0P625 = 4'h4, ARA_SE_0P75 = 4'h5, ARA_DI_3P0 = 4'h6, ARA_DI_2P5 = 4'h7,
      ARA_UNI_3P0 = 4'h8, ARA_UNI_1P5 = 4'ha, ARA_UNI_1P25 = 4'hb,
      ARA_DI_1P5 = 4'hc, ARA_DI_1P25 = 4'hd, ARA_DI_0P75 = 4'he, ARA_DI_0P625 = 4'hf
   } ara_span_t;
   // event order inside the interrupt status and mask registers
   typedef enum logic [1:0] {
      ARA_EV_IN_HI = 2'h0, ARA_EV_IN_LO = 2'h1, ARA_EV_SUP_HI = 2'h2, ARA_EV_SUP_LO = 2'h3
   } ara_event_t;
endpackage
